// ---- rtl/iro_readout.sv ----
// Image readout, dark calibration and exposure retiming with AXI4-Lite registers.
// Assumes pix_in_data belongs to the array position addressed at each pix_tick.
//
// Behaviour
// - Register 17 bit 7 shuffles columns, odds first
// - Register 22 bit 3 mirrors columns
// - Register 22 bit 4 mirrors rows
// - Dark calibration targets black code 64
// - Average dark pixels, compare with target
// - Register 45 picks user or internal offset
// - Leaky integrator yields the correction offset
// - Reload integrator on exposure, power-up, suspend exit
// - Modes: report, apply internal, apply user
// - Default divider gives one pixel per two clocks
// - Divider code: 1, 2, else twice bits 3:1 plus two
// - Frame length 524 default, at most 1023
// - Line length 762 default, at most 1023
// - Pixel period is twice divider over clock
// - Integration is coarse times line plus fine
// - Exposure and gain apply at frame start only
// - Status bit 0 shows exposure pending
// - Gain applies one frame after exposure
// - Page writes suspend retiming
// - Audio gain 3 bits, reference power-down
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module iro_readout import iro_pkg::*;
#(
    parameter int DARK_LOG = 11
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [8:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [8:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Sensor side
    input wire logic suspend,
    input wire logic [9:0] pix_in_data,
    output logic pix_tick,
    output logic [9:0] rd_col,
    output logic [8:0] rd_row,
    output logic rd_valid,
    output logic frame_start,
    output logic [9:0] pix_out_data,
    output logic pix_out_valid,
    // Applied exposure and gain
    output logic [9:0] exp_coarse,
    output logic [9:0] exp_fine,
    output logic [7:0] exp_gain,
    output logic [19:0] exp_pixels,
    // Audio controls
    output logic [2:0] mic_amp_gain,
    output logic mic_ref_pd
);
    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] r_readout;
    logic [7:0] r_mirror;
    logic [7:0] r_user_ofs;
    logic [7:0] r_dark_ctrl;
    logic [7:0] r_audio;
    logic [3:0] r_clk_div;
    logic [9:0] r_line_len;
    logic [9:0] r_frame_len;
    logic [9:0] sh_coarse;
    logic [9:0] sh_fine;
    logic [7:0] sh_gain;
    logic pending;
    logic page_open;

    logic aw_hold;
    logic w_hold;
    logic [6:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane;
    logic wr_go;
    logic wr_hit;
    logic page_wr;
    logic [31:0] rd_word;
    logic rd_hit;

    logic [9:0] line_len;
    logic [9:0] frame_len;
    logic [9:0] col;
    logic [9:0] row;
    logic line_end;
    logic frame_edge;
    logic [9:0] hx;
    logic [9:0] vr;
    logic in_vis;
    logic in_dark;
    logic suspend_d;
    logic apply;
    logic gain_due;
    logic [7:0] gain_stage;
    logic [9:0] dark_avg;
    logic signed [10:0] dark_ofs;
    logic signed [11:0] corr;
    iro_dc_mode_t dc_mode;

    if (DARK_LOG < 4 || DARK_LOG > 11)
        $error("iro_readout: DARK_LOG out of range");

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign awready = !aw_hold;
    assign wready = !w_hold;
    assign wr_go = aw_hold && w_hold && !bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            aw_idx <= 7'h00;
        end
        else if (awvalid && !aw_hold)
        begin
            aw_hold <= 1'b1;
            aw_idx <= awaddr[8:2];
        end
        else if (wr_go)
            aw_hold <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end
        else if (wvalid && !w_hold)
        begin
            w_hold <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
        end
        else if (wr_go)
            w_hold <= 1'b0;
    end

    always_comb
    begin
        unique case (aw_idx)
            REG_READOUT, REG_MIRROR, REG_USER_OFS, REG_DARK_CTRL, REG_AUDIO,
            REG_CLK_DIV, REG_LINE_HI, REG_LINE_LO, REG_FRAME_HI, REG_FRAME_LO,
            REG_EXP_COARSE_HI, REG_EXP_COARSE_LO, REG_EXP_FINE_HI,
            REG_EXP_FINE_LO, REG_EXP_GAIN: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        page_wr = wr_go && w_lane && (aw_idx >= REG_EXP_COARSE_HI)
            && (aw_idx <= REG_EXP_GAIN);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // Control registers; a cleared strobe leaves the byte untouched
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_readout <= 8'h00;
            r_mirror <= 8'h00;
            r_user_ofs <= 8'h00;
            r_dark_ctrl <= 8'h00;
            r_audio <= 8'h00;
            r_clk_div <= 4'h0;
            r_line_len <= DEF_LINE_LEN;
            r_frame_len <= DEF_FRAME_LEN;
        end
        else if (wr_go && w_lane)
        begin
            unique case (aw_idx)
                REG_READOUT: r_readout <= w_byte;
                REG_MIRROR: r_mirror <= w_byte;
                REG_USER_OFS: r_user_ofs <= w_byte;
                REG_DARK_CTRL: r_dark_ctrl <= w_byte;
                REG_AUDIO: r_audio <= w_byte;
                REG_CLK_DIV: r_clk_div <= w_byte[3:0];
                REG_LINE_HI: r_line_len[9:8] <= w_byte[1:0];
                REG_LINE_LO: r_line_len[7:0] <= w_byte;
                REG_FRAME_HI: r_frame_len[9:8] <= w_byte[1:0];
                REG_FRAME_LO: r_frame_len[7:0] <= w_byte;
                default: ;
            endcase
        end
    end

    // Exposure page shadows wait for a frame boundary
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sh_coarse <= DEF_COARSE;
            sh_fine <= DEF_FINE;
            sh_gain <= DEF_GAIN;
        end
        else if (page_wr)
        begin
            unique case (aw_idx)
                REG_EXP_COARSE_HI: sh_coarse[9:8] <= w_byte[1:0];
                REG_EXP_COARSE_LO: sh_coarse[7:0] <= w_byte;
                REG_EXP_FINE_HI: sh_fine[9:8] <= w_byte[1:0];
                REG_EXP_FINE_LO: sh_fine[7:0] <= w_byte;
                default: sh_gain <= w_byte;
            endcase
        end
    end

    // Page stays open until its last byte; a strobed write to another register also closes it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            page_open <= 1'b0;
        else if (page_wr)
            page_open <= (aw_idx != REG_EXP_GAIN);
        else if (wr_go && w_lane)
            page_open <= 1'b0;
    end

    // A new write wins over the clear at the same boundary
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pending <= 1'b0;
        else if (page_wr)
            pending <= 1'b1;
        else if (apply)
            pending <= 1'b0;
    end

    always_comb
    begin
        rd_hit = 1'b1;
        unique case (araddr[8:2])
            REG_READOUT: rd_word = 32'(r_readout);
            REG_MIRROR: rd_word = 32'(r_mirror);
            REG_USER_OFS: rd_word = 32'(r_user_ofs);
            REG_DARK_CTRL: rd_word = 32'(r_dark_ctrl);
            REG_DARK_AVG: rd_word = 32'(dark_avg);
            REG_STATUS: rd_word = 32'(pending);
            REG_AUDIO: rd_word = 32'(r_audio);
            REG_CLK_DIV: rd_word = 32'(r_clk_div);
            REG_LINE_HI: rd_word = 32'(r_line_len[9:8]);
            REG_LINE_LO: rd_word = 32'(r_line_len[7:0]);
            REG_FRAME_HI: rd_word = 32'(r_frame_len[9:8]);
            REG_FRAME_LO: rd_word = 32'(r_frame_len[7:0]);
            REG_EXP_COARSE_HI: rd_word = 32'(sh_coarse[9:8]);
            REG_EXP_COARSE_LO: rd_word = 32'(sh_coarse[7:0]);
            REG_EXP_FINE_HI: rd_word = 32'(sh_fine[9:8]);
            REG_EXP_FINE_LO: rd_word = 32'(sh_fine[7:0]);
            REG_EXP_GAIN: rd_word = 32'(sh_gain);
            default:
            begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign arready = !rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && !rvalid)
        begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // ****************************************
    // Timing: divider and line/frame counters
    // ****************************************
    // Lengths can only be raised; smaller codes fall back to the default
    assign line_len = (r_line_len < DEF_LINE_LEN) ? DEF_LINE_LEN : r_line_len;
    assign frame_len = (r_frame_len < DEF_FRAME_LEN) ? DEF_FRAME_LEN : r_frame_len;

    iro_pix_div u_div
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(!suspend),
        .clk_div(r_clk_div),
        .pix_tick(pix_tick)
    );

    assign line_end = pix_tick && (col >= line_len - 10'h001);
    assign frame_edge = line_end && (row >= frame_len - 10'h001);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            col <= 10'h000;
            row <= 10'h000;
        end
        else if (line_end)
        begin
            col <= 10'h000;
            row <= frame_edge ? 10'h000 : row + 10'h001;
        end
        else if (pix_tick)
            col <= col + 10'h001;
    end

    // ****************************************
    // Readout order
    // ****************************************
    always_comb
    begin
        if (!r_readout[SHUFFLE_BIT])
            hx = col;
        else if (col < SHUF_HALF)
            hx = {col[8:0], 1'b1};
        else
            hx = {col[8:0] - SHUF_HALF[8:0], 1'b0};
        vr = row - VIS_FIRST;
        in_vis = (col < ACT_COLS) && (row >= VIS_FIRST) && (vr < VIS_ROWS);
        in_dark = (col < ACT_COLS) && (row >= DARK_FIRST) && (row <= DARK_LAST);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_col <= 10'h000;
            rd_row <= 9'h000;
            rd_valid <= 1'b0;
        end
        else if (pix_tick)
        begin
            rd_col <= r_mirror[HMIRROR_BIT] ? ACT_COLS - 10'h001 - hx : hx;
            rd_row <= r_mirror[VMIRROR_BIT] ? 9'(VIS_ROWS - 10'h001 - vr) : vr[8:0];
            rd_valid <= in_vis;
        end
    end

    // ****************************************
    // Dark calibration
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            suspend_d <= 1'b0;
        else
            suspend_d <= suspend;
    end

    iro_dark_cal #(.LOGN(DARK_LOG)) u_dark
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(frame_edge),
        .sample(pix_tick && in_dark),
        .pix(pix_in_data),
        .reload(apply || (suspend_d && !suspend)),
        .avg(dark_avg),
        .offset(dark_ofs)
    );

    // Code 3 is not a mode; it behaves as report only
    always_comb
    begin
        unique case (r_dark_ctrl[1:0])
            2'h1: dc_mode = DC_INTERNAL;
            2'h2: dc_mode = DC_USER;
            default: dc_mode = DC_REPORT;
        endcase
        unique case (dc_mode)
            DC_INTERNAL: corr = $signed({2'h0, pix_in_data}) - 12'(dark_ofs);
            DC_USER: corr = $signed({2'h0, pix_in_data}) - 12'($signed(r_user_ofs));
            DC_REPORT: corr = $signed({2'h0, pix_in_data});
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pix_out_data <= 10'h000;
            pix_out_valid <= 1'b0;
            frame_start <= 1'b0;
        end
        else
        begin
            frame_start <= frame_edge;
            pix_out_valid <= pix_tick && in_vis;
            if (pix_tick)
            begin
                if (corr < 0)
                    pix_out_data <= 10'h000;
                else if (corr > 12'sh3FF)
                    pix_out_data <= 10'h3FF;
                else
                    pix_out_data <= corr[9:0];
            end
        end
    end

    // ****************************************
    // Exposure and gain retiming
    // ****************************************
    assign apply = frame_edge && pending && !page_open && !page_wr;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            exp_coarse <= DEF_COARSE;
            exp_fine <= DEF_FINE;
            gain_stage <= DEF_GAIN;
        end
        else if (apply)
        begin
            exp_coarse <= sh_coarse;
            exp_fine <= sh_fine;
            gain_stage <= sh_gain;
        end
    end

    // Gain lags a frame since exposure shows up one frame late
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            exp_gain <= DEF_GAIN;
            gain_due <= 1'b0;
        end
        else if (frame_edge)
        begin
            if (gain_due)
                exp_gain <= gain_stage;
            gain_due <= apply;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            exp_pixels <= 20'h00000;
        else
            exp_pixels <= 20'(exp_coarse) * 20'(line_len) + {10'h000, exp_fine};
    end

    // ****************************************
    // Audio controls
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mic_amp_gain <= 3'h0;
            mic_ref_pd <= 1'b0;
        end
        else
        begin
            mic_amp_gain <= r_audio[2:0];
            mic_ref_pd <= r_audio[MIC_REF_PD_BIT];
        end
    end
endmodule : iro_readout

// ---- rtl/iro_pkg.sv ----
// Shared constants for the image readout and exposure control block.
// Assumes a 10 MHz aclk and register access over AXI4-Lite.
package iro_pkg;
    // ****************************************
    // Register indices (byte address = index * 4)
    // ****************************************
    localparam logic [6:0] REG_READOUT = 7'h11;
    localparam logic [6:0] REG_MIRROR = 7'h16;
    localparam logic [6:0] REG_EXP_COARSE_HI = 7'h20;
    localparam logic [6:0] REG_EXP_COARSE_LO = 7'h21;
    localparam logic [6:0] REG_EXP_FINE_HI = 7'h22;
    localparam logic [6:0] REG_EXP_FINE_LO = 7'h23;
    localparam logic [6:0] REG_EXP_GAIN = 7'h24;
    localparam logic [6:0] REG_USER_OFS = 7'h2C;
    localparam logic [6:0] REG_DARK_CTRL = 7'h2D;
    localparam logic [6:0] REG_DARK_AVG = 7'h2E;
    localparam logic [6:0] REG_STATUS = 7'h30;
    localparam logic [6:0] REG_AUDIO = 7'h32;
    localparam logic [6:0] REG_CLK_DIV = 7'h33;
    localparam logic [6:0] REG_LINE_HI = 7'h52;
    localparam logic [6:0] REG_LINE_LO = 7'h53;
    localparam logic [6:0] REG_FRAME_HI = 7'h61;
    localparam logic [6:0] REG_FRAME_LO = 7'h62;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int SHUFFLE_BIT = 7;
    localparam int HMIRROR_BIT = 3;
    localparam int VMIRROR_BIT = 4;
    localparam int PENDING_BIT = 0;
    localparam int MIC_REF_PD_BIT = 3;
    // ****************************************
    // Reset values and geometry
    // ****************************************
    localparam logic [9:0] DEF_FRAME_LEN = 10'h20C;
    localparam logic [9:0] DEF_LINE_LEN = 10'h2FA;
    localparam logic [9:0] DEF_COARSE = 10'h20A;
    localparam logic [9:0] DEF_FINE = 10'h2FA;
    localparam logic [7:0] DEF_GAIN = 8'h00;
    localparam logic [9:0] BLACK_LEVEL = 10'h040;
    localparam logic [9:0] DARK_FIRST = 10'h013;
    localparam logic [9:0] DARK_LAST = 10'h018;
    localparam logic [9:0] VIS_FIRST = 10'h019;
    localparam logic [9:0] VIS_ROWS = 10'h1E4;
    localparam logic [9:0] ACT_COLS = 10'h284;
    localparam logic [9:0] SHUF_HALF = 10'h142;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {DC_REPORT, DC_INTERNAL, DC_USER} iro_dc_mode_t;
endpackage : iro_pkg

// ---- rtl/iro_pix_div.sv ----
// Pixel-rate enable from the 4-bit clock divider code.
// Assumes one clock; the tick is a one-cycle enable.
`timescale 1ns/1ps
module iro_pix_div
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic run,
    input wire logic [3:0] clk_div,
    // Tick
    output logic pix_tick
);
    logic [4:0] cnt;
    logic [4:0] term;

    // Pixel period is 2*N clocks; bit 0 ignored above code 1
    always_comb
    begin
        if (clk_div == 4'h0)
            term = 5'h01;
        else if (clk_div == 4'h1)
            term = 5'h03;
        else
            term = {clk_div[3:1], 2'h3};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt <= 5'h00;
        else if (!run)
            cnt <= 5'h00;
        else if (cnt >= term)
            cnt <= 5'h00;
        else
            cnt <= cnt + 5'h01;
    end

    assign pix_tick = run && (cnt >= term);
endmodule : iro_pix_div

// ---- rtl/iro_dark_cal.sv ----
// Dark row averaging and leaky integrator for black level offset.
// Assumes samples arrive only on shielded dark rows, cleared each frame.
`timescale 1ns/1ps
module iro_dark_cal import iro_pkg::*;
#(
    parameter int LOGN = 11,
    parameter int LEAK = 3
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic clr,
    input wire logic sample,
    input wire logic [9:0] pix,
    input wire logic reload,
    // Results
    output logic [9:0] avg,
    output logic signed [10:0] offset
);
    if (LOGN < 4 || LOGN > 11 || LEAK < 1 || LEAK > 6)
        $error("iro_dark_cal: parameter out of range");

    localparam int F = 4;
    logic [9+LOGN:0] sum;
    logic [9+LOGN:0] sum_next;
    logic [LOGN:0] cnt;
    logic fire;
    logic reload_pend;
    logic signed [10+F:0] integ;
    logic signed [10+F:0] target;

    assign sum_next = sum + {{LOGN{1'b0}}, pix};
    assign fire = sample && !cnt[LOGN] && (cnt == {1'b0, {LOGN{1'b1}}});
    assign target = $signed({1'b0, sum_next[9+LOGN:LOGN], {F{1'b0}}});

    // Accumulate a fixed count of dark pixels per frame
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clr)
        begin
            sum <= '0;
            cnt <= '0;
        end
        else if (sample && !cnt[LOGN])
        begin
            sum <= sum_next;
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            avg <= 10'h000;
        else if (fire)
            avg <= sum_next[9+LOGN:LOGN];
    end

    // Set wins over the clear taken by the update
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            reload_pend <= 1'b1;
        else if (reload)
            reload_pend <= 1'b1;
        else if (fire)
            reload_pend <= 1'b0;
    end

    // Stale history is replaced, not blended
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            integ <= '0;
        else if (fire && reload_pend)
            integ <= target;
        else if (fire)
            integ <= integ + ((target - integ) >>> LEAK);
    end

    assign offset = $signed({1'b0, integ[9+F:F]}) - $signed({1'b0, BLACK_LEVEL});
endmodule : iro_dark_cal

// ---- sim/iro_readout_asserts.sv ----
// Readout port checker.
// Assumes binding onto every readout instance.
`timescale 1ns/1ps
module iro_readout_asserts import iro_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Sensor side
    input wire logic suspend,
    input wire logic pix_tick,
    input wire logic pix_out_valid,
    input wire logic rd_valid,
    input wire logic [9:0] rd_col,
    input wire logic [8:0] rd_row,
    input wire logic [9:0] exp_coarse,
    input wire logic [9:0] exp_fine,
    input wire logic [7:0] exp_gain
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bresp moved");
    a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("rdata moved");
    a_ready_busy: assert property ($rose(bvalid) |-> !$past(awready) && !$past(wready))
        else $error("ready early");
    a_tick_gap: assert property (pix_tick |=> !pix_tick)
        else $error("tick gap");
    a_out_lag: assert property (pix_out_valid |-> $past(pix_tick))
        else $error("out no tick");
    a_susp_quiet: assert property (suspend && $past(suspend) |-> !pix_tick)
        else $error("suspend tick");
    a_exp_frame: assert property (
        $changed(exp_coarse) || $changed(exp_fine) |-> $past(pix_tick))
        else $error("exp timing");
    a_gain_frame: assert property (
        $changed(exp_gain) |-> $past(pix_tick) && $stable(exp_coarse))
        else $error("gain timing");
    a_addr_range: assert property (
        rd_valid |-> rd_col < ACT_COLS && rd_row < 9'(VIS_ROWS))
        else $error("addr range");
    c_slverr: cover property (bvalid && bready && bresp == RESP_SLVERR);
    c_read: cover property (rvalid && rready);
    c_pixel: cover property (pix_out_valid);
endmodule : iro_readout_asserts
bind iro_readout iro_readout_asserts u_iro_readout_asserts (.*);

// ---- sim/iro_array_model.sv ----
// Pixel array stand-in, one sample per tick.
// Assumes sampling only in a tick cycle.
`timescale 1ns/1ps
module iro_array_model import iro_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Readout
    input wire logic pix_tick,
    input wire logic [9:0] rd_col,
    output logic [9:0] pix_in_data
);
    // Garbage after each tick exposes stale sampling
    initial pix_in_data = BLACK_LEVEL;
    always @(posedge aclk)
        pix_in_data <= pix_tick ? ~pix_in_data : BLACK_LEVEL + {7'h0, rd_col[2:0]};
endmodule : iro_array_model

// ---- sim/test_iro_readout.sv ----
// Readout bench.
// Assumes array model and bound checker.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_iro_readout import iro_pkg::*;;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, suspend = 0, awready, wready, bvalid, arready, rvalid;
    logic pix_tick, rd_valid, pix_out_valid, frame_start, mic_ref_pd;
    logic [8:0] awaddr = '0, araddr = '0, rd_row;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic [9:0] pix_in_data, rd_col, pix_out_data, exp_coarse, exp_fine, c, f;
    logic [7:0] exp_gain, a;
    logic [19:0] exp_pixels;
    logic [2:0] mic_amp_gain;
    logic [33:0] exp_q[$], e_item;
    int error_cnt = 0, check_count = 0;
    always #50 aclk = ~aclk;
    iro_readout #(.DARK_LOG(4)) u_iro_readout (.*);
    iro_array_model u_iro_array_model (.aclk, .pix_tick, .rd_col, .pix_in_data);
    // Check answers against notes
    always @(posedge aclk)
        if ((bvalid && bready) || (rvalid && rready))
        begin
            e_item = exp_q.size() ? exp_q.pop_front() : 34'h3FFFFFFFF;
            `CHK((bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata}, e_item)
        end
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic hold(ref logic s, input int lim);
        int n;
        n = 0;
        @(negedge aclk);
        while (s !== 1'b1 && n < lim)
        begin
            n++;
            @(negedge aclk);
        end
        if (n >= lim)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask : hold
    task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic s,
        input logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {idx, 2'h0, 24'h0, d, 3'h0, s};
        {awvalid, wvalid, bready} <= 3'h7;
        exp_q.push_back({r, 32'h0});
        hold(awready, 300);
        @(posedge aclk);
        {awvalid, wvalid} <= 2'h0;
        hold(bvalid, 300);
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] idx, input logic [33:0] e);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {idx, 2'h0, 2'h3};
        exp_q.push_back(e);
        hold(arready, 300);
        @(posedge aclk);
        arvalid <= 1'b0;
        hold(rvalid, 300);
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd
    // Tick spacing
    task automatic gap(input int e);
        int g;
        repeat (2) hold(pix_tick, 300);
        g = 0;
        do
        begin
            @(negedge aclk);
            g++;
        end while (pix_tick !== 1'b1 && g < 99);
        `CHK(g, e)
    endtask : gap
    initial
    begin
        void'($urandom(46899));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // ****************************************
        // Reset values and refusals
        // ****************************************
        rd(REG_FRAME_HI, 34'h2);
        rd(REG_FRAME_LO, 34'h0C);
        rd(REG_LINE_HI, 34'h2);
        rd(REG_LINE_LO, 34'hFA);
        rd(REG_STATUS, 34'h0);
        `CHK(exp_pixels, 20'(522 * 762 + 762))
        rd(7'h7F, {RESP_SLVERR, 32'h0});
        wr(7'h7F, 8'hA5, 1'b1, RESP_SLVERR);
        $display("reset done");
        // ****************************************
        // Divider, modes, audio, exposure
        // ****************************************
        for (int k = 0; k < 16; k++)
        begin
            wr(REG_CLK_DIV, 8'(k), 1'b1, RESP_OKAY);
            gap(k < 2 ? 2 * k + 2 : 4 * (k >> 1) + 4);
        end
        wr(REG_CLK_DIV, 8'h00, 1'b1, RESP_OKAY);
        $display("divider done");
        wr(REG_READOUT, 8'h80, 1'b1, RESP_OKAY);
        wr(REG_MIRROR, 8'h18, 1'b1, RESP_OKAY);
        wr(REG_USER_OFS, 8'($urandom), 1'b1, RESP_OKAY);
        for (int m = 0; m < 3; m++)
            wr(REG_DARK_CTRL, 8'(m), 1'b1, RESP_OKAY);
        suspend <= 1'b1;
        repeat (20) @(posedge aclk);
        suspend <= 1'b0;
        hold(pix_out_valid, 60000);
        $display("readout done");
        a = 8'($urandom);
        wr(REG_AUDIO, {4'h0, a[3:0]}, 1'b1, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK({mic_ref_pd, mic_amp_gain}, a[3:0])
        wr(REG_AUDIO, {4'h0, ~a[3:0]}, 1'b0, RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK({mic_ref_pd, mic_amp_gain}, a[3:0])
        c = 10'($urandom_range(522, 0));
        f = 10'($urandom_range(762, 11));
        wr(REG_EXP_COARSE_HI, {6'h0, c[9:8]}, 1'b1, RESP_OKAY);
        wr(REG_EXP_COARSE_LO, c[7:0], 1'b1, RESP_OKAY);
        wr(REG_EXP_FINE_HI, {6'h0, f[9:8]}, 1'b1, RESP_OKAY);
        wr(REG_EXP_FINE_LO, f[7:0], 1'b1, RESP_OKAY);
        wr(REG_EXP_GAIN, 8'($urandom | 1), 1'b1, RESP_OKAY);
        rd(REG_STATUS, 34'h1);
        `CHK({exp_coarse, exp_gain}, {DEF_COARSE, DEF_GAIN})
        $display("exposure done");
        give_verdict();
    end
endmodule : test_iro_readout
